// *** verilog/igec_cfg.svh ***
// Constants for the input group event conditioner: offsets, resets, timing
`ifndef IGEC_CFG_SVH
`define IGEC_CFG_SVH
`define CLK_PERIOD_NS 25
`define MS_TIME_NS    1000000
`define MS_CYCLES     (`MS_TIME_NS / `CLK_PERIOD_NS)
`define WIN_TIME_MS   100
`define NUM_CH        12
`define NUM_GRP       3
`define GRP_FIELD_W   4
`define OFF_GROUP     8'h00
`define OFF_CH_BASE   8'h10
`define OFF_LEVEL     8'h40
`define OFF_INT_STAT  8'h44
`define OFF_INT_MASK  8'h48
`define GROUP_RESET   12'h222
`define CH_RESET      32'h0101_0100
`define RESP_OKAY     2'h0
`define RESP_SLVERR   2'h2
`endif

// *** verilog/igec_pkg.sv ***
// Types shared by the input group event conditioner
package igec_pkg;
  typedef enum logic [1:0] {FUNC_DISCRETE = 2'h0, FUNC_COUNTER = 2'h1, FUNC_TSTAMP = 2'h2} func_type;
  typedef enum logic [1:0] {EDGE_BOTH = 2'h0, EDGE_RISE = 2'h1, EDGE_FALL = 2'h2} edge_type;
  typedef enum logic {DEB_STEADY = 1'b0, DEB_INTEG = 1'b1} deb_type;
  // Group field, one nibble per group
  typedef struct packed {
    logic       dechat;
    logic       deb_sel;
    logic [1:0] func;
  } grp_cfg_type;
  // Channel register layout
  typedef struct packed {
    logic [7:0] chat_time;
    logic [7:0] chat_count;
    logic [7:0] debounce;
    logic [4:0] unused;
    logic [1:0] edge_sel;
    logic       disabled;
  } ch_cfg_type;
  // Per-channel filter state
  typedef struct packed {
    logic       level;
    logic       event_q;
    logic [7:0] cnt;
    logic [7:0] chat_n;
    logic [7:0] win;
    logic       suppress;
  } chan_state_type;
  // Top-level state
  typedef struct packed {
    logic [11:0]       sync1;
    logic [11:0]       sync2;
    logic [15:0]       ms_div;
    logic              ms_tick;
    logic [7:0]        win_div;
    logic              win_tick;
    logic [11:0]       grp;
    logic [11:0][31:0] ch;
    logic [11:0]       int_stat;
    logic [11:0]       int_mask;
    logic              irq;
    logic              awready;
    logic              wready;
    logic              aw_got;
    logic              w_got;
    logic [7:0]        waddr;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              arready;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
  } top_state_type;
endpackage

// *** verilog/igec_channel.sv ***
// One input channel: debounce, edge selection and dechatter
`timescale 1ns/100ps
`include "igec_cfg.svh"
module igec_channel (
  // Clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // Time bases
  input  wire logic            ms_tick,
  input  wire logic            win_tick,
  // Synchronised field level and configuration
  input  wire logic            raw,
  input  wire igec_pkg::ch_cfg_type cfg,
  input  wire logic            deb_sel,
  input  wire logic            dechat_en,
  // Conditioned outputs
  output logic                 level,
  output logic                 event_q
);
  import igec_pkg::*;
  chan_state_type s;       // Registered state
  chan_state_type next_s;  // Next state

  // Filter, edge and dechatter decisions
  always_comb begin
    logic chg;
    logic edge_ok;
    chg     = 1'b0;
    edge_ok = 1'b0;
    next_s  = s;
    next_s.event_q = 1'b0;
    if (cfg.disabled) begin
      next_s = '0;  // Channel off holds zero
    end else begin
      if (cfg.debounce == 8'h00) begin
        next_s.cnt = 8'h00;
        chg = (raw != s.level);  // No added delay
      end else if (deb_sel == DEB_STEADY) begin
        if (raw == s.level) begin
          next_s.cnt = 8'h00;  // Change reverted, timing restarts
        end else if (ms_tick) begin
          if (s.cnt + 8'h01 >= cfg.debounce) begin
            chg = 1'b1;  // Held for the full time
            next_s.cnt = 8'h00;
          end else begin
            next_s.cnt = s.cnt + 8'h01;
          end
        end
      end else begin
        // Up/down integrator saturating at the filter time
        if (ms_tick && raw && s.cnt < cfg.debounce) begin
          next_s.cnt = s.cnt + 8'h01;
        end else if (ms_tick && !raw && s.cnt != 8'h00) begin
          next_s.cnt = s.cnt - 8'h01;
        end
        chg = (!s.level && next_s.cnt >= cfg.debounce) || (s.level && next_s.cnt == 8'h00);
      end
      if (chg) begin
        next_s.level = ~s.level;
      end
      // Edge qualification
      case (cfg.edge_sel)
        EDGE_BOTH: edge_ok = chg;
        EDGE_RISE: edge_ok = chg && !s.level;
        EDGE_FALL: edge_ok = chg && s.level;
        default:   edge_ok = 1'b0;  // Undefined code gives no events
      endcase
      if (!dechat_en) begin
        // Chatter settings ignored when off
        next_s.chat_n   = 8'h00;
        next_s.win      = 8'h00;
        next_s.suppress = 1'b0;
        next_s.event_q  = edge_ok;
      end else begin
        // Window runs from the first counted edge
        if (win_tick && s.chat_n != 8'h00) begin
          if (s.win + 8'h01 >= cfg.chat_time) begin
            next_s.win      = 8'h00;
            next_s.chat_n   = 8'h00;
            next_s.suppress = 1'b0;  // Window over, events resume
          end else begin
            next_s.win = s.win + 8'h01;
          end
        end
        if (edge_ok && !next_s.suppress) begin
          next_s.event_q = 1'b1;
          next_s.chat_n  = next_s.chat_n + 8'h01;
          // Limit reached, mute the rest of the window
          if (next_s.chat_n >= cfg.chat_count) begin
            next_s.suppress = 1'b1;
          end
        end
      end
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level   = s.level;
  assign event_q = s.event_q;

  chk_disabled_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    cfg.disabled |=> !s.level && !s.event_q) else $error("disabled channel not held at zero");
  chk_bypass_follow: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg.disabled && cfg.debounce == 8'h00) |=> s.level == $past(raw))
    else $error("zero debounce did not pass input");
  chk_steady_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    (!cfg.disabled && deb_sel == DEB_STEADY && cfg.debounce != 8'h00 && raw == s.level) |=> s.cnt == 8'h00)
    else $error("steady filter did not restart");
  chk_integ_reach: assert property (@(posedge aclk) disable iff (!aresetn)
    ($rose(s.level) && deb_sel == DEB_INTEG && cfg.debounce != 8'h00 && $stable(cfg.debounce))
    |-> s.cnt >= cfg.debounce) else $error("integrator accepted early");
  chk_edge_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.event_q && cfg.edge_sel == EDGE_RISE && $stable(cfg.edge_sel)) |-> s.level)
    else $error("falling event with rising selection");
  chk_edge_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    (s.event_q && cfg.edge_sel == EDGE_FALL && $stable(cfg.edge_sel)) |-> !s.level)
    else $error("rising event with falling selection");
  chk_chatter_mute: assert property (@(posedge aclk) disable iff (!aresetn)
    (dechat_en && s.suppress && !win_tick && !cfg.disabled) |=> !s.event_q)
    else $error("event passed while muted");
endmodule // igec_channel

// *** verilog/input_group_event_conditioner.sv ***
// Input group event conditioner for channels 4 to 15 with AXI4-Lite registers
//
// Summary of operation
// - Group function code, time stamping after reset
// - Steady debounce: change held full time
// - Integrating debounce: up/down count reaches time
// - Group dechatter enable for counter and time-stamp groups, ignored when off or for discrete groups
// - Disabled channel stops, output held zero
// - Edge select: both, rising or falling
// - Debounce time 0 to 255 ms
// - Debounce time zero bypasses filtering
// - Chatter count limit 1 to 255
// - Chatter window 1 to 255 x 100 ms
//
// Local design decisions: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "igec_cfg.svh"
module input_group_event_conditioner #(
  parameter int MS_CYCLES = `MS_CYCLES  // Cycles per millisecond tick
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Field inputs, channel 4 at bit 0
  input  wire logic [11:0] field_in,
  // Conditioned outputs to the time-stamp logic
  output logic [11:0]      cond_level,
  output logic [11:0]      cond_event,
  output logic [5:0]       group_function,
  output logic             irq,
  // AXI4-Lite write channels
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready
);
  import igec_pkg::*;

  localparam logic [4:0] IDX_GROUP = 5'd0;   // Group settings
  localparam logic [4:0] IDX_LEVEL = 5'd13;  // Live levels
  localparam logic [4:0] IDX_STAT  = 5'd14;  // Sticky events
  localparam logic [4:0] IDX_MASK  = 5'd15;  // Interrupt mask
  localparam logic [4:0] IDX_NONE  = 5'd31;  // Unmapped
  localparam logic [15:0] MS_LAST  = 16'(MS_CYCLES - 1);
  localparam logic [7:0]  WIN_LAST = 8'(`WIN_TIME_MS - 1);

  top_state_type s;       // Registered state
  top_state_type next_s;  // Next state
  logic [11:0]   lvl;     // Channel levels
  logic [11:0]   evt;     // Channel event pulses

  // Word address to register index; 1 to 12 are channels
  function automatic logic [4:0] decode(input logic [7:0] a);
    logic [7:0] off;
    off = a - `OFF_CH_BASE;
    if (a[1:0] != 2'b00) begin
      decode = IDX_NONE;
    end else if (a == `OFF_GROUP) begin
      decode = IDX_GROUP;
    end else if (a >= `OFF_CH_BASE && a < `OFF_LEVEL) begin
      decode = 5'(off[7:2]) + 5'd1;
    end else if (a == `OFF_LEVEL) begin
      decode = IDX_LEVEL;
    end else if (a == `OFF_INT_STAT) begin
      decode = IDX_STAT;
    end else if (a == `OFF_INT_MASK) begin
      decode = IDX_MASK;
    end else begin
      decode = IDX_NONE;
    end
  endfunction

  // Byte-lane merge of a write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[8*b +: 8] = nw[8*b +: 8];
      end
    end
    merge = r;
  endfunction

  // Next-state logic for time bases, registers and bus
  always_comb begin
    logic [4:0]  widx;
    logic [4:0]  ridx;
    logic [31:0] w1c;
    logic [31:0] tmp;
    widx   = decode(s.waddr);
    ridx   = decode(araddr);
    w1c    = 32'h0000_0000;
    tmp    = 32'h0000_0000;
    next_s = s;
    // Two-stage synchroniser; only the second stage feeds the filters
    next_s.sync1 = field_in;
    next_s.sync2 = s.sync1;
    // Millisecond enable from the clock divider
    next_s.ms_tick = 1'b0;
    if (s.ms_div >= MS_LAST) begin
      next_s.ms_div  = 16'h0000;
      next_s.ms_tick = 1'b1;
    end else begin
      next_s.ms_div = s.ms_div + 16'h0001;
    end
    // 100 ms chatter window enable
    next_s.win_tick = 1'b0;
    if (s.ms_tick) begin
      if (s.win_div >= WIN_LAST) begin
        next_s.win_div  = 8'h00;
        next_s.win_tick = 1'b1;
      end else begin
        next_s.win_div = s.win_div + 8'h01;
      end
    end
    // Address and data may arrive in either order
    if (awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.waddr  = awaddr;
    end
    if (wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.wdata = wdata;
      next_s.wstrb = wstrb;
    end
    // Perform the write once both halves are held
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got  = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp  = `RESP_OKAY;
      if (widx == IDX_GROUP) begin
        tmp = merge({20'h0_0000, s.grp}, s.wdata, s.wstrb);
        next_s.grp = tmp[11:0];  // Function, filter type, dechatter
      end else if (widx >= 5'd1 && widx <= 5'd12) begin
        next_s.ch[widx - 5'd1] = merge(s.ch[widx - 5'd1], s.wdata, s.wstrb);
      end else if (widx == IDX_STAT) begin
        w1c = merge(32'h0000_0000, s.wdata, s.wstrb);
      end else if (widx == IDX_MASK) begin
        tmp = merge({20'h0_0000, s.int_mask}, s.wdata, s.wstrb);
        next_s.int_mask = tmp[11:0];
      end else if (widx == IDX_LEVEL) begin
        next_s.bresp = `RESP_OKAY;  // Read-only, write ignored
      end else begin
        next_s.bresp = `RESP_SLVERR;  // Unmapped address
      end
    end else if (s.bvalid && bready) begin
      next_s.bvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready  = !next_s.w_got && !next_s.bvalid;
    // A new event beats a clear in the same cycle
    next_s.int_stat = (s.int_stat & ~w1c[11:0]) | evt;
    next_s.irq      = |(next_s.int_stat & next_s.int_mask);
    // Read channel: one read at a time
    if (arvalid && s.arready) begin
      next_s.arready = 1'b0;
      next_s.rvalid  = 1'b1;
      next_s.rresp   = `RESP_OKAY;
      case (ridx)
        IDX_GROUP: next_s.rdata = {20'h0_0000, s.grp};
        IDX_LEVEL: next_s.rdata = {20'h0_0000, lvl};
        IDX_STAT:  next_s.rdata = {20'h0_0000, s.int_stat};
        IDX_MASK:  next_s.rdata = {20'h0_0000, s.int_mask};
        IDX_NONE: begin
          next_s.rdata = 32'h0000_0000;
          next_s.rresp = `RESP_SLVERR;
        end
        default:   next_s.rdata = s.ch[ridx - 5'd1];
      endcase
    end else if (s.rvalid && rready) begin
      next_s.rvalid  = 1'b0;
      next_s.arready = 1'b1;
    end
  end

  // State register with reset defaults
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s          <= '0;
      s.grp      <= `GROUP_RESET;  // Time stamping by default
      s.ch       <= {`NUM_CH{`CH_RESET}};
      s.awready  <= 1'b1;
      s.wready   <= 1'b1;
      s.arready  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // One conditioner per channel, settings from its group
  generate
    for (genvar i = 0; i < `NUM_CH; i++) begin : g_ch
      grp_cfg_type gc;
      assign gc = s.grp[`GRP_FIELD_W*(i/4) +: `GRP_FIELD_W];
      igec_channel u_ch (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .ms_tick   (s.ms_tick),
        .win_tick  (s.win_tick),
        .raw       (s.sync2[i]),
        .cfg       (ch_cfg_type'(s.ch[i])),
        .deb_sel   (gc.deb_sel),
        .dechat_en (gc.dechat && gc.func != FUNC_DISCRETE),  // Counter and event inputs only
        .level     (lvl[i]),
        .event_q   (evt[i])
      );
    end
    for (genvar g = 0; g < `NUM_GRP; g++) begin : g_fn
      assign group_function[2*g +: 2] = s.grp[`GRP_FIELD_W*g +: 2];
    end
  endgenerate

  // Outputs straight from flip-flops
  assign cond_level = lvl;
  assign cond_event = evt;
  assign irq        = s.irq;
  assign awready    = s.awready;
  assign wready     = s.wready;
  assign bvalid     = s.bvalid;
  assign bresp      = s.bresp;
  assign arready    = s.arready;
  assign rvalid     = s.rvalid;
  assign rdata      = s.rdata;
  assign rresp      = s.rresp;

  // Write sequence: both halves held, answer next edge
  sequence wr_both_held;
    s.aw_got && s.w_got && !s.bvalid;
  endsequence
  sequence wr_answered;
    s.bvalid && !s.aw_got && !s.w_got;
  endsequence

  chk_func_default: assert property (@(posedge aclk)
    $rose(aresetn) |-> group_function == 6'h2A) else $error("group function not time stamping after reset");
  chk_write_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    wr_both_held |=> wr_answered) else $error("write not answered");
  chk_sticky_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (|evt) |=> (s.int_stat & $past(evt)) == $past(evt)) else $error("event lost from status");
  chk_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    irq == |(s.int_stat & s.int_mask)) else $error("interrupt level wrong");
  chk_ms_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    s.ms_tick |-> s.ms_div == 16'h0000 && !$past(s.ms_tick)) else $error("millisecond tick misplaced");
  chk_win_tick: assert property (@(posedge aclk) disable iff (!aresetn)
    s.win_tick |-> $past(s.ms_tick) && s.win_div == 8'h00) else $error("window tick not on ms boundary");
  chk_count_limit: assert property (@(posedge aclk) disable iff (!aresetn)
    (g_ch[0].u_ch.s.chat_n >= s.ch[0][23:16] && s.ch[0][23:16] != 8'h00 && g_ch[0].u_ch.dechat_en
     && !s.win_tick && $stable(s.ch[0])) |=> !evt[0]) else $error("chatter count exceeded");
endmodule // input_group_event_conditioner

// *** verif/field_lines.sv ***
// Field input lines model: dry contacts seen by the conditioner
`timescale 1ns/100ps
module field_lines (
  // Clock
  input  wire logic        aclk,
  // Contact states requested by the bench
  input  wire logic [11:0] contact,
  // Field levels toward the conditioner
  output logic      [11:0] field_in
);
  // A contact reaches its line one clock later, on the same aclk edge that the design samples on;
  // the lines are unknown only until the first edge, well inside reset
  always @(posedge aclk) begin
    field_in <= contact;
  end
endmodule // field_lines

// *** verif/testbench.sv ***
// Self-checking bench for the input group event conditioner
`timescale 1ns/100ps
`include "igec_cfg.svh"
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin failures++; \
  $display("CHECK FAILED at %0t got %h expected %h", $time, (got), (exp)); end end
module testbench;
  import igec_pkg::*;
  localparam int MS = 20;             // Short millisecond keeps filter times brief
  logic        aclk, aresetn;         // Clock and reset
  logic [11:0] contact, field_in;     // Contacts and field lines
  logic [11:0] cond_level, cond_event;
  logic [5:0]  group_function;
  logic        irq;
  logic [7:0]  awaddr, araddr;        // Register bus
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  int          failures, comparisons; // Verdict counters
  int          ev_cnt [12];           // Events seen per channel

  field_lines lines (.aclk(aclk), .contact(contact), .field_in(field_in));

  input_group_event_conditioner #(.MS_CYCLES(MS)) dut (
    .aclk(aclk), .aresetn(aresetn), .field_in(field_in), .cond_level(cond_level),
    .cond_event(cond_event), .group_function(group_function), .irq(irq),
    .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready));

  // Clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Count events on the falling edge, so reads at the rising edge never race
  always @(negedge aclk) begin
    for (int i = 0; i < 12; i++) begin
      if (cond_event[i] === 1'b1) ev_cnt[i]++;
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write; the trailing idle edge keeps bready from toggling twice in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      test_done();
    end
    `CHK(bresp, er)
    bready <= 1'b0;
    @(posedge aclk);
  endtask

  // Bus read with expected data and response
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 100);
    if (n >= 100) begin
      failures++;
      test_done();
    end
    `CHK(rdata, ed)
    `CHK(rresp, er)
    rready <= 1'b0;
    @(posedge aclk);
  endtask

  // Reset values, unmapped place, every function code
  task automatic t_regs();
    `CHK(group_function, 6'h2A)
    rd(`OFF_GROUP, `GROUP_RESET, `RESP_OKAY);
    rd(`OFF_CH_BASE, `CH_RESET, `RESP_OKAY);
    rd(`OFF_CH_BASE + 8'h2C, `CH_RESET, `RESP_OKAY);
    rd(`OFF_INT_MASK, 32'h0000_0000, `RESP_OKAY);
    rd(8'h80, 32'h0000_0000, `RESP_SLVERR);
    wr(8'h80, 32'hFFFF_FFFF, `RESP_SLVERR);
    wr(`OFF_GROUP, 32'h0000_0210, `RESP_OKAY);
    cyc(2);
    `CHK(group_function, 6'h24)
    wr(`OFF_GROUP, 32'h0000_0222, `RESP_OKAY);
    $display("Test registers done");
  endtask

  // Zero debounce passes at once; interrupt raised, cleared and masked
  task automatic t_bypass();
    int b;
    wr(`OFF_CH_BASE, 32'h0101_0000, `RESP_OKAY);
    wr(`OFF_INT_MASK, 32'h0000_0001, `RESP_OKAY);
    b = ev_cnt[0];
    contact[0] <= 1'b1;
    cyc(6);
    `CHK(cond_level[0], 1'b1)
    `CHK(ev_cnt[0] - b, 1)
    `CHK(irq, 1'b1)
    rd(`OFF_LEVEL, 32'h0000_0001, `RESP_OKAY);
    wr(`OFF_INT_STAT, 32'h0000_0001, `RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b0)
    contact[0] <= 1'b0;
    cyc(6);
    `CHK(irq, 1'b1)
    wr(`OFF_INT_MASK, 32'h0000_0000, `RESP_OKAY);
    cyc(2);
    `CHK(irq, 1'b0)
    $display("Test bypass done");
  endtask

  // Each edge selection on channel 5
  task automatic t_edges();
    int b;
    for (int e = 0; e < 3; e++) begin
      wr(`OFF_CH_BASE + 8'h04, 32'h0101_0000 | (e << 1), `RESP_OKAY);
      b = ev_cnt[1];
      contact[1] <= 1'b1;
      cyc(6);
      `CHK(ev_cnt[1] - b, int'(e != 2))
      contact[1] <= 1'b0;
      cyc(6);
      `CHK(ev_cnt[1] - b, (e == 0) ? 2 : 1)
    end
    $display("Test edges done");
  endtask

  // Disabled channel stays at zero; re-enabled it follows after 1 ms
  task automatic t_disable();
    int b;
    wr(`OFF_CH_BASE + 8'h08, 32'h0101_0101, `RESP_OKAY);
    b = ev_cnt[2];
    contact[2] <= 1'b1;
    cyc(100);
    `CHK(cond_level[2], 1'b0)
    `CHK(ev_cnt[2] - b, 0)
    wr(`OFF_CH_BASE + 8'h08, 32'h0101_0100, `RESP_OKAY);
    cyc(100);
    `CHK(cond_level[2], 1'b1)
    contact[2] <= 1'b0;
    cyc(100);
    $display("Test disable done");
  endtask

  // Long highs with short dips: only the integrating filter reaches 4 ms
  task automatic t_filter(input logic sel, input logic exp);
    wr(`OFF_GROUP, 32'h0000_0222 | (32'(sel) << 2), `RESP_OKAY);
    wr(`OFF_CH_BASE + 8'h0C, 32'h0101_0400, `RESP_OKAY);
    repeat (5) begin
      contact[3] <= 1'b1;
      cyc(45);
      contact[3] <= 1'b0;
      cyc(5);
    end
    `CHK(cond_level[3], exp)
    cyc(200);
    `CHK(cond_level[3], 1'b0)
    $display("Test filter done");
  endtask

  // Chatter count of 2 in a two-unit window, so a free-running window tick
  // can never end the window inside the burst; nib is the group 0 field
  task automatic t_dechat(input logic [3:0] nib, input int exp);
    int b;
    wr(`OFF_GROUP, 32'h0000_0220 | 32'(nib), `RESP_OKAY);
    wr(`OFF_CH_BASE, 32'h0202_0000, `RESP_OKAY);
    cyc(4200);
    b = ev_cnt[0];
    repeat (2) begin
      contact[0] <= 1'b1;
      cyc(10);
      contact[0] <= 1'b0;
      cyc(10);
    end
    `CHK(ev_cnt[0] - b, exp)
    if (exp == 2) begin
      // Window ends at most two ticks after its first edge
      cyc(4200);
      contact[0] <= 1'b1;
      cyc(10);
      `CHK(ev_cnt[0] - b, 3)
      contact[0] <= 1'b0;
      cyc(10);
    end
    $display("Test dechatter done");
  endtask

  // Main sequence
  initial begin
    aresetn = 1'b0;
    contact = 12'h000;
    {awaddr, araddr, wdata, wstrb} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    failures = 0;
    comparisons = 0;
    foreach (ev_cnt[i]) ev_cnt[i] = 0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_bypass();
    t_edges();
    t_disable();
    t_filter(1'b0, 1'b0);
    t_filter(1'b1, 1'b1);
    t_dechat(4'h2, 4);
    t_dechat(4'h8, 4);
    t_dechat(4'hA, 2);
    test_done();
  end
endmodule // testbench
